// [design/csi_consts.svh]
// Constants of the curtain status indicator: offsets, fields, resets, timing.
`ifndef CSI_CONSTS_SVH
`define CSI_CONSTS_SVH
// ****************************************************************
// Register offsets (byte addresses).
// ****************************************************************
`define CSI_CTRL_OFS    8'h00
`define CSI_CODE_OFS    8'h04
`define CSI_STATUS_OFS  8'h08
// ****************************************************************
// Control register fields and reset values.
// ****************************************************************
`define CSI_CTRL_STARTUP_BIT 0
`define CSI_CTRL_RXCH2_BIT   1
`define CSI_CTRL_STARTUP_RST 1'b1
`define CSI_CTRL_RXCH2_RST   1'b0
`define CSI_CODE_RST         8'h00
// ****************************************************************
// Bus responses.
// ****************************************************************
`define CSI_RESP_OKAY   2'b00
`define CSI_RESP_SLVERR 2'b10
// ****************************************************************
// Timing: clock rate and flash rates in hertz.
// ****************************************************************
`define CSI_CLK_HZ  50000000
`define CSI_SLOW_HZ 1
`define CSI_FAST_HZ 10
`endif

// [design/csi_pkg.sv]
// Types shared by the curtain status indicator modules.
package csi_pkg;
  // Two-colour lamp drive.
  typedef struct packed {
    logic red;
    logic green;
  } csi_lamp_s;
  // Conditions supplied by the detection and switching logic.
  typedef struct packed {
    logic       field_interrupted;
    logic       misaligned;
    logic       tx_channel_two;
    logic       external_error;
    logic       internal_error;
    logic       weak_signal;
    logic       interlock_locked;
    logic       control_open;
    logic [1:0] operating_mode;
    logic       tx_failed;
    logic       tx_supply_ok;
  } csi_cond_s;
  // Indication shown on the primary status lamp, highest priority first.
  typedef enum logic [4:0] {
    IND_INT  = 5'b00001,
    IND_EXT  = 5'b00010,
    IND_STOP = 5'b00100,
    IND_WEAK = 5'b01000,
    IND_OK   = 5'b10000
  } csi_ind_e;
  // Symbol on the seven-segment display.
  typedef enum logic [4:0] {
    SYM_BLANK = 5'b00001,
    SYM_CH1   = 5'b00010,
    SYM_CH2   = 5'b00100,
    SYM_EXT   = 5'b01000,
    SYM_INT   = 5'b10000
  } csi_sym_e;
  // Status register layout, low bits first from the right.
  typedef struct packed {
    logic       tx_second_lamp;
    csi_lamp_s  tx_status_lamp;
    csi_lamp_s  output_lamp;
    logic       interlock_status_lamp;
    csi_lamp_s  primary_status_lamp;
    csi_ind_e   ind;
  } csi_status_s;
endpackage

// [design/csi_flash.sv]
// Flash divider: a square wave at fifty percent duty and a tick per edge.
`timescale 1ns/1ps
`default_nettype none
module csi_flash import csi_pkg::*; #(
  parameter int unsigned HALF = 25000000
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Flash outputs.
  output var  logic tick,
  output var  logic phase
);
  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          phase;
  } csi_flash_s;
  csi_flash_s st, next_st;
  // Terminal count marks each half period.
  assign tick  = (st.cnt == CW'(HALF - 1));
  assign phase = st.phase;
  // Count the half period and toggle the phase at its end.
  always_comb begin
    next_st = st;
    if (tick) begin
      next_st.cnt   = '0;
      next_st.phase = ~st.phase;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end
  // Register the state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  property p_duty_hold;
    @(posedge sys_clk) disable iff (!rst_n) !tick |=> $stable(phase);
  endproperty
  a_duty_hold: assert property (p_duty_hold)
    else $error("Flash phase moved between ticks.");
endmodule // csi_flash
`default_nettype wire

// [design/csi_display.sv]
// Seven-segment encoder for channel codes and error codes.
`timescale 1ns/1ps
`default_nettype none
module csi_display import csi_pkg::*; (
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Symbol and code to show.
  input  wire csi_sym_e   sym,
  input  wire logic [7:0] code,
  // Segments gfedcba, digit 2 leftmost, active high.
  output var  logic [6:0] digit2,
  output var  logic [6:0] digit1,
  output var  logic [6:0] digit0
);
  typedef struct packed {
    logic [6:0] d2;
    logic [6:0] d1;
    logic [6:0] d0;
  } csi_disp_s;
  csi_disp_s st, next_st;
  // Hex digit to segment pattern.
  function automatic logic [6:0] seg(input logic [3:0] v);
    case (v)
      4'h0: seg = 7'h3f;
      4'h1: seg = 7'h06;
      4'h2: seg = 7'h5b;
      4'h3: seg = 7'h4f;
      4'h4: seg = 7'h66;
      4'h5: seg = 7'h6d;
      4'h6: seg = 7'h7d;
      4'h7: seg = 7'h07;
      4'h8: seg = 7'h7f;
      4'h9: seg = 7'h6f;
      4'ha: seg = 7'h77;
      4'hb: seg = 7'h7c;
      4'hc: seg = 7'h39;
      4'hd: seg = 7'h5e;
      4'he: seg = 7'h79;
      default: seg = 7'h71;
    endcase
  endfunction
  // Channel shows C and its number; errors show a letter and two digits.
  always_comb begin
    next_st = '0;
    case (sym)
      SYM_CH1: begin
        next_st.d1 = seg(4'hc);
        next_st.d0 = seg(4'h1);
      end
      SYM_CH2: begin
        next_st.d1 = seg(4'hc);
        next_st.d0 = seg(4'h2);
      end
      SYM_EXT: begin
        next_st.d2 = seg(4'he);
        next_st.d1 = seg(code[7:4]);
        next_st.d0 = seg(code[3:0]);
      end
      SYM_INT: begin
        next_st.d2 = seg(4'hf);
        next_st.d1 = seg(code[7:4]);
        next_st.d0 = seg(code[3:0]);
      end
      default: next_st = '0;
    endcase
  end
  // Register the segments.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign digit2 = st.d2;
  assign digit1 = st.d1;
  assign digit0 = st.d0;
endmodule // csi_display
`default_nettype wire

// [design/csi_indicator.sv]
// Status lamps and display driver of the light curtain, AXI4-Lite slave.
`include "csi_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module csi_indicator import csi_pkg::*; #(
  parameter int unsigned SLOW_HALF = `CSI_CLK_HZ / (2 * `CSI_SLOW_HZ),
  parameter int unsigned FAST_HALF = `CSI_CLK_HZ / (2 * `CSI_FAST_HZ)
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Conditions from the detection and switching logic.
  input  wire csi_cond_s   cond,
  // Lamps.
  output var  csi_lamp_s   primary_status_lamp,
  output var  logic        interlock_status_lamp,
  output var  csi_lamp_s   output_lamp,
  output var  csi_lamp_s   tx_status_lamp,
  output var  logic        tx_second_lamp,
  // Seven-segment display.
  output var  logic [6:0]  digit2,
  output var  logic [6:0]  digit1,
  output var  logic [6:0]  digit0,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef struct packed {
    csi_ind_e    ind;
    csi_lamp_s   prim;
    logic        ilk;
    csi_lamp_s   outl;
    csi_lamp_s   txl;
    logic        tx2;
    csi_sym_e    sym;
    logic        startup;
    logic        rx_ch2;
    logic [7:0]  err_code;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        run;
  } csi_top_s;
  csi_top_s st, next_st;
  logic        slow_phase;
  logic        fast_phase;
  logic        mismatch;
  logic        stop;
  logic        ctl_open_mode;
  csi_status_s status;
  // ****************************************************************
  // Flash rates and display.
  // ****************************************************************
  csi_flash #(.HALF(SLOW_HALF)) u_slow (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (),
    .phase   (slow_phase)
  );
  csi_flash #(.HALF(FAST_HALF)) u_fast (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tick    (),
    .phase   (fast_phase)
  );
  csi_display u_disp (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sym     (st.sym),
    .code    (st.err_code),
    .digit2  (digit2),
    .digit1  (digit1),
    .digit0  (digit0)
  );
  // ****************************************************************
  // Condition decode.
  // ****************************************************************
  // Stop covers interruption, misalignment and channel mismatch.
  assign mismatch = cond.tx_channel_two != st.rx_ch2;
  assign stop = cond.field_interrupted | cond.misaligned | mismatch;
  assign ctl_open_mode = cond.control_open && (cond.operating_mode != 2'h0);
  assign status = '{tx_second_lamp: st.tx2, tx_status_lamp: st.txl,
                    output_lamp: st.outl, interlock_status_lamp: st.ilk,
                    primary_status_lamp: st.prim, ind: st.ind};
  // ****************************************************************
  // Next state: lamps, display and bus.
  // ****************************************************************
  always_comb begin
    next_st = st;
    // Checks start one edge after reset is released.
    next_st.run = 1'b1;
    // Highest pending condition wins the primary lamp.
    if (cond.internal_error) begin
      next_st.ind = IND_INT;
    end else if (cond.external_error) begin
      next_st.ind = IND_EXT;
    end else if (stop) begin
      next_st.ind = IND_STOP;
    end else if (cond.weak_signal) begin
      next_st.ind = IND_WEAK;
    end else begin
      next_st.ind = IND_OK;
    end
    next_st.prim = '0;
    case (next_st.ind)
      IND_INT:  next_st.prim.red = fast_phase;
      IND_EXT:  next_st.prim.red = slow_phase;
      IND_STOP: next_st.prim.red = 1'b1;
      IND_WEAK: next_st.prim.green = slow_phase;
      IND_OK:   next_st.prim.green = 1'b1;
      default:  next_st.prim = '0;
    endcase
    // Output lamp mirrors the switching outputs.
    next_st.outl.red = stop | cond.internal_error
                     | cond.external_error;
    next_st.outl.green = ~next_st.outl.red;
    // Interlock lamp: open control circuit flashes when operating_mode is not 0, ready shows steady.
    if (ctl_open_mode) begin
      next_st.ilk = slow_phase;
    end else begin
      next_st.ilk = cond.interlock_locked
                  && !cond.field_interrupted;
    end
    // Transmitter lamps: dark unpowered, red failed, green per channel.
    next_st.txl.red = cond.tx_supply_ok && cond.tx_failed;
    next_st.txl.green = cond.tx_supply_ok && !cond.tx_failed;
    next_st.tx2 = next_st.txl.green && cond.tx_channel_two;
    // Display: channel during start-up, else the error letter, blank with no error.
    if (st.startup) begin
      next_st.sym = st.rx_ch2 ? SYM_CH2 : SYM_CH1;
    end else if (cond.internal_error) begin
      next_st.sym = SYM_INT;
    end else if (cond.external_error) begin
      next_st.sym = SYM_EXT;
    end else begin
      next_st.sym = SYM_BLANK;
    end
    // Write address and data are taken in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `CSI_RESP_OKAY;
      case ({st.awaddr[7:2], 2'b00})
        `CSI_CTRL_OFS: begin
          if (st.wstrb[0]) begin
            next_st.startup = st.wdata[`CSI_CTRL_STARTUP_BIT];
            next_st.rx_ch2 = st.wdata[`CSI_CTRL_RXCH2_BIT];
          end
        end
        `CSI_CODE_OFS: begin
          if (st.wstrb[0]) begin
            next_st.err_code = st.wdata[7:0];
          end
        end
        `CSI_STATUS_OFS: next_st.bresp = `CSI_RESP_OKAY;
        default: next_st.bresp = `CSI_RESP_SLVERR;
      endcase
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    // Read answers one cycle after the address is taken.
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `CSI_RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `CSI_CTRL_OFS:   next_st.rdata = {30'h0, st.rx_ch2, st.startup};
        `CSI_CODE_OFS:   next_st.rdata = {24'h0, st.err_code};
        `CSI_STATUS_OFS: next_st.rdata = 32'(status);
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = `CSI_RESP_SLVERR;
        end
      endcase
    end
  end
  // Register the state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.ind <= IND_OK;
      st.sym <= SYM_BLANK;
      st.startup <= `CSI_CTRL_STARTUP_RST;
      st.rx_ch2 <= `CSI_CTRL_RXCH2_RST;
      st.err_code <= `CSI_CODE_RST;
    end else begin
      st <= next_st;
    end
  end
  // Bus handshakes and registered outputs.
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign primary_status_lamp = st.prim;
  assign interlock_status_lamp = st.ilk;
  assign output_lamp = st.outl;
  assign tx_status_lamp = st.txl;
  assign tx_second_lamp = st.tx2;
  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking @(posedge sys_clk); endclocking
  // The release edge still shows reset values, so checks skip it.
  default disable iff (!rst_n || !st.run);
  logic no_fault;
  assign no_fault = !cond.internal_error && !cond.external_error;
  sequence s_both_faults;
    cond.internal_error && cond.external_error;
  endsequence
  sequence s_int_shown;
    st.ind == IND_INT && st.prim.red == $past(fast_phase);
  endsequence
  property p_clear_green;
    (no_fault && !stop && !cond.weak_signal) |=> st.prim == 2'b01;
  endproperty
  a_clear_green: assert property (p_clear_green)
    else $error("Primary lamp not steady green when clear.");
  property p_output_red;
    cond.field_interrupted |=> output_lamp.red && !output_lamp.green;
  endproperty
  a_output_red: assert property (p_output_red)
    else $error("Output lamp not red while field interrupted.");
  property p_stop_red;
    (no_fault && (cond.field_interrupted || cond.misaligned))
      |=> st.prim == 2'b10;
  endproperty
  a_stop_red: assert property (p_stop_red)
    else $error("Primary lamp not steady red on stop.");
  property p_startup_code;
    st.startup ##1 st.startup
      |-> st.sym == ($past(st.rx_ch2) ? SYM_CH2 : SYM_CH1);
  endproperty
  a_startup_code: assert property (p_startup_code)
    else $error("Channel code not shown during start-up.");
  property p_mismatch_red;
    (no_fault && mismatch) |=> st.prim == 2'b10;
  endproperty
  a_mismatch_red: assert property (p_mismatch_red)
    else $error("Primary lamp not red on channel mismatch.");
  property p_ext_flash;
    (cond.external_error && !cond.internal_error)
      |=> st.prim.red == $past(slow_phase) && !st.prim.green;
  endproperty
  a_ext_flash: assert property (p_ext_flash)
    else $error("External error flash wrong.");
  property p_int_flash;
    s_both_faults |=> s_int_shown;
  endproperty
  a_int_flash: assert property (p_int_flash)
    else $error("Internal error not shown first at fast rate.");
  property p_weak_flash;
    (no_fault && !stop && cond.weak_signal)
      |=> st.prim.green == $past(slow_phase) && !st.prim.red;
  endproperty
  a_weak_flash: assert property (p_weak_flash)
    else $error("Weak signal flash wrong.");
  property p_ilk_ready;
    (!ctl_open_mode && cond.interlock_locked && !cond.field_interrupted)
      |=> interlock_status_lamp;
  endproperty
  a_ilk_ready: assert property (p_ilk_ready)
    else $error("Interlock lamp not lit when ready.");
  property p_ilk_flash;
    ctl_open_mode |=> interlock_status_lamp == $past(slow_phase);
  endproperty
  a_ilk_flash: assert property (p_ilk_flash)
    else $error("Interlock lamp not flashing on open circuit.");
  property p_tx_lamp;
    !cond.tx_supply_ok |=> tx_status_lamp == 2'b00 && !tx_second_lamp;
  endproperty
  a_tx_lamp: assert property (p_tx_lamp)
    else $error("Transmitter lamp lit without supply.");
  property p_tx_failed;
    (cond.tx_supply_ok && cond.tx_failed) |=> tx_status_lamp == 2'b10;
  endproperty
  a_tx_failed: assert property (p_tx_failed)
    else $error("Transmitter lamp not red when failed.");
  property p_tx_channel;
    (cond.tx_supply_ok && !cond.tx_failed)
      |=> tx_second_lamp == $past(cond.tx_channel_two);
  endproperty
  a_tx_channel: assert property (p_tx_channel)
    else $error("Transmitter channel lamps wrong.");
  property p_ext_code;
    (cond.external_error && !cond.internal_error && !st.startup)
      |=> st.sym == SYM_EXT;
  endproperty
  a_ext_code: assert property (p_ext_code)
    else $error("External error code not shown.");
  property p_int_code;
    (cond.internal_error && !st.startup) |=> st.sym == SYM_INT;
  endproperty
  a_int_code: assert property (p_int_code)
    else $error("Internal error code not shown.");
endmodule // csi_indicator
`default_nettype wire

// [bench/csi_operator.sv]
// Operator model that times the lit and dark spans of one watched lamp.
`timescale 1ns/1ps
`default_nettype none
module csi_operator (
  // Clock.
  input  wire logic sys_clk,
  // Lamp being watched.
  input  wire logic lamp,
  // Last lit and dark spans in cycles, zero once the lamp is steady.
  output var  int   lit_len,
  output var  int   dark_len
);
  int   cnt    = 0;
  int   lit_q  = 0;
  int   dark_q = 0;
  logic last   = 1'b0;
  // The spans reach the bench through plain assignments.
  assign lit_len  = lit_q;
  assign dark_len = dark_q;
  // A person sees only how long the lamp stays lit and how long dark.
  always @(posedge sys_clk) begin
    cnt <= cnt + 1;
    last <= lamp;
    if (lamp !== last) begin
      cnt <= 1;
      if (last)
        lit_q <= cnt;
      else
        dark_q <= cnt;
    end else if (cnt > 40) begin
      lit_q <= 0;
      dark_q <= 0;
    end
  end
endmodule  // csi_operator
`default_nettype wire

// [bench/curtain_status_indicator_tb.sv]
// Self-checking bench of the curtain status indicator.
`include "csi_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %0h seen %0h", n, e, s); end end
module curtain_status_indicator_tb import csi_pkg::*;;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  csi_cond_s   cond    = 12'h001;
  csi_cond_s   base    = 12'h001;
  csi_cond_s   c;
  csi_lamp_s   prim, outl, txl;
  logic        intl, tx2, watch;
  logic [6:0]  d2, d1, d0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata, rd;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [1:0]  sel     = 2'h0;
  int          lit, dark;
  int          err_count   = 0;
  int          comparisons = 0;

  // Free-running system clock.
  always #10 sys_clk = ~sys_clk;
  // The operator looks at the lamp picked by sel.
  assign watch = (sel == 2'h0) ? prim.red : (sel == 2'h1) ? prim.green : intl;

  // Short flash half periods keep the run brief.
  csi_indicator #(.SLOW_HALF(8), .FAST_HALF(2)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cond(cond),
    .primary_status_lamp(prim), .interlock_status_lamp(intl),
    .output_lamp(outl), .tx_status_lamp(txl), .tx_second_lamp(tx2),
    .digit2(d2), .digit1(d1), .digit0(d0),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  csi_operator i_op (.sys_clk(sys_clk), .lamp(watch), .lit_len(lit),
    .dark_len(dark));

  // ****************************************************************
  // Bus cycles and checks.
  // ****************************************************************
  // One write; address and data are dropped each as it is taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    bready <= 1'b0;
    `CHK("bvalid", 1'b1, bvalid)
    `CHK("bresp", e, bresp)
    // One idle edge so a next call never sets bready in this step.
    @(posedge sys_clk);
  endtask
  // One read; the data land in rd.
  task automatic rdr(input logic [7:0] a, input logic [1:0] e);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rready <= 1'b0;
    rd = rdata;
    `CHK("rvalid", 1'b1, rvalid)
    `CHK("rresp", e, rresp)
    // One idle edge so a next call never sets rready in this step.
    @(posedge sys_clk);
  endtask
  // Applies conditions and lets the lamps and digits settle.
  task automatic setc(input csi_cond_s v);
    cond <= v;
    repeat (4) @(posedge sys_clk);
  endtask
  // Reads the indication field of the status register.
  task automatic st(input csi_ind_e e);
    rdr(`CSI_STATUS_OFS, `CSI_RESP_OKAY);
    `CHK("ind", e, rd[4:0])
  endtask
  // Watches one lamp and compares its lit and dark spans.
  task automatic flash(input logic [1:0] s, input int h);
    sel <= s;
    repeat (80) @(posedge sys_clk);
    `CHK("lit", h, lit)
    `CHK("dark", h, dark)
  endtask
  // True when a two-symbol code sits on adjacent digits.
  function automatic logic has2(input logic [6:0] a, input logic [6:0] b);
    return (d2 === a && d1 === b) || (d1 === a && d0 === b);
  endfunction
  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ****************************************************************
  // Tests.
  // ****************************************************************
  // Main sequence after a reset of six cycles.
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdr(`CSI_CTRL_OFS, `CSI_RESP_OKAY);
    `CHK("ctrl", 2'b01, rd[1:0])
    rdr(`CSI_CODE_OFS, `CSI_RESP_OKAY);
    `CHK("code", `CSI_CODE_RST, rd[7:0])
    wr(8'h0c, 32'hff, `CSI_RESP_SLVERR);
    rdr(8'h0c, `CSI_RESP_SLVERR);
    `CHK("unmapped", 32'h0, rd)
    $display("test registers done");
    setc(base);
    `CHK("ch1", 1'b1, has2(7'h39, 7'h06))
    `CHK("tx2", 1'b0, tx2)
    wr(`CSI_CTRL_OFS, 32'h3, `CSI_RESP_OKAY);
    setc(base);
    `CHK("ch2", 1'b1, has2(7'h39, 7'h5b))
    `CHK("prim", 2'b10, prim)
    st(IND_STOP);
    c = base;
    c.tx_channel_two = 1'b1;
    setc(c);
    `CHK("tx2", 1'b1, tx2)
    `CHK("prim", 2'b01, prim)
    wr(`CSI_CTRL_OFS, 32'h0, `CSI_RESP_OKAY);
    setc(c);
    `CHK("prim", 2'b10, prim)
    $display("test channels done");
    setc(base);
    `CHK("prim", 2'b01, prim)
    `CHK("out", 1'b0, outl.red)
    `CHK("blank", 21'h0, {d2, d1, d0})
    st(IND_OK);
    c = base;
    c.field_interrupted = 1'b1;
    c.interlock_locked = 1'b1;
    setc(c);
    `CHK("prim", 2'b10, prim)
    `CHK("out", 2'b10, outl)
    `CHK("intl", 1'b0, intl)
    c = base;
    c.misaligned = 1'b1;
    setc(c);
    `CHK("prim", 2'b10, prim)
    $display("test field done");
    wr(`CSI_CODE_OFS, 32'h12, `CSI_RESP_OKAY);
    c = base;
    c.external_error = 1'b1;
    c.weak_signal = 1'b1;
    c.field_interrupted = 1'b1;
    setc(c);
    st(IND_EXT);
    `CHK("e_code", {7'h79, 7'h06, 7'h5b}, {d2, d1, d0})
    `CHK("green", 1'b0, prim.green)
    flash(2'h0, 8);
    c.internal_error = 1'b1;
    setc(c);
    st(IND_INT);
    `CHK("f_code", {7'h71, 7'h06, 7'h5b}, {d2, d1, d0})
    flash(2'h0, 2);
    c = base;
    c.weak_signal = 1'b1;
    setc(c);
    st(IND_WEAK);
    `CHK("red", 1'b0, prim.red)
    flash(2'h1, 8);
    $display("test errors done");
    c = base;
    c.interlock_locked = 1'b1;
    setc(c);
    `CHK("intl", 1'b1, intl)
    flash(2'h2, 0);
    c.control_open = 1'b1;
    for (int m = 0; m < 4; m++) begin
      c.operating_mode = m[1:0];
      setc(c);
      flash(2'h2, (m == 0) ? 0 : 8);
    end
    $display("test interlock done");
    c = base;
    c.tx_supply_ok = 1'b0;
    setc(c);
    `CHK("tx", 2'b00, txl)
    c.tx_supply_ok = 1'b1;
    c.tx_failed = 1'b1;
    setc(c);
    `CHK("tx", 2'b10, txl)
    $display("test transmitter done");
    summarize();
  end

  // Watchdog well beyond the fewer than a thousand cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
endmodule  // curtain_status_indicator_tb
`default_nettype wire
